// File: hw/cks_pkg.sv
package cks_pkg;

   // Widths
   localparam int KEY_W = 256;
   localparam int WORD_W = 32;
   localparam int INSTR_W = 4;
   localparam int LOAD_W = 3;
   localparam int HOLD_CNT_W = 8;
   localparam int EC_CNT_W = 8;
   localparam int DEC_CNT_W = 8;

   // Instruction codes seen on the JTAG decoder and the core request port
   localparam logic [INSTR_W-1:0] INSTR_KEY_PROGRAM = 4'h1;
   localparam logic [INSTR_W-1:0] INSTR_KEY_CLEAR = 4'h2;
   localparam logic [INSTR_W-1:0] INSTR_PROVISION = 4'h3;
   localparam logic [INSTR_W-1:0] INSTR_CLEAR_ALL = 4'h4;
   localparam logic [INSTR_W-1:0] INSTR_READBACK = 4'h5;
   localparam logic [INSTR_W-1:0] INSTR_IDCODE = 4'h6;
   localparam logic [INSTR_W-1:0] INSTR_BYPASS = 4'hF;

   // Bitstream loading schemes
   localparam logic [LOAD_W-1:0] LOAD_PASSIVE_SERIAL = 3'h0;
   localparam logic [LOAD_W-1:0] LOAD_FAST_PASSIVE_PARALLEL = 3'h1;
   localparam logic [LOAD_W-1:0] LOAD_ACTIVE_SERIAL_FAST = 3'h2;
   localparam logic [LOAD_W-1:0] LOAD_ACTIVE_SERIAL_UPDATE_FAST = 3'h3;
   localparam logic [LOAD_W-1:0] LOAD_ACTIVE_SERIAL = 3'h4;
   localparam logic [LOAD_W-1:0] LOAD_PARALLEL_FLASH = 3'h5;

   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int STATUS_HOLD_NS = 1000;
   localparam int STATUS_HOLD_CYCLES = (STATUS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [HOLD_CNT_W-1:0] HOLD_LAST = HOLD_CNT_W'(STATUS_HOLD_CYCLES - 1);
   localparam int ERR_CHECK_CYCLES = 256;
   localparam logic [EC_CNT_W-1:0] EC_LAST = EC_CNT_W'(ERR_CHECK_CYCLES - 1);

   // Key scrambling
   localparam int KEY_ROT = 67;
   localparam logic [KEY_W-1:0] SCRAMBLE_MASK = {8{32'h5A3C_96E1}};

   // Reset values
   localparam logic SYNC_RESET = 1'b0;
   localparam logic [KEY_W-1:0] KEY_RESET = '0;

   typedef enum logic [1:0] {
      CKS_MODE_KEYLESS,
      CKS_MODE_KEYED,
      CKS_MODE_PROVISION
   } cks_mode_e;

endpackage

// File: hw/cks_key_store.sv
module cks_key_store
   import cks_pkg::*;
(
   input wire logic clk,
   input wire logic bat_nrst,
   input wire logic wr,
   input wire logic clr,
   input wire logic [KEY_W-1:0] key_in,
   output logic key_valid,
   output logic [KEY_W-1:0] key_work
);

   logic [KEY_W-1:0] stored;
   logic [KEY_W-1:0] scrambled;
   logic [KEY_W-1:0] next_stored;
   logic next_key_valid;

   // Fixed bit permutation plus mask; the cells never hold the entered pattern
   for (genvar i = 0; i < KEY_W; i++) begin : g_scr
      assign scrambled[i] = key_in[(i + KEY_W - KEY_ROT) % KEY_W] ^ SCRAMBLE_MASK[i];
      assign key_work[(i + KEY_W - KEY_ROT) % KEY_W] = stored[i] ^ SCRAMBLE_MASK[i];
   end

   always_comb begin
      next_stored = stored;
      next_key_valid = key_valid;
      if (clr) begin
         // Zero, not inverted or masked, so nothing of the old key survives
         next_stored = KEY_RESET;
         next_key_valid = 1'b0;
      end else if (wr) begin
         next_stored = scrambled;
         next_key_valid = 1'b1;
      end
   end

   // Lives on the battery reset only; core resets leave the key alone
   always_ff @(posedge clk or negedge bat_nrst) begin
      if (!bat_nrst) begin
         stored <= KEY_RESET;
         key_valid <= 1'b0;
      end else begin
         stored <= next_stored;
         key_valid <= next_key_valid;
      end
   end

endmodule

// File: hw/cks_stream_decrypt.sv
module cks_stream_decrypt
   import cks_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic in_valid,
   input wire logic [WORD_W-1:0] in_data,
   input wire logic in_encrypted,
   input wire logic [KEY_W-1:0] key,
   output logic out_valid,
   output logic [WORD_W-1:0] out_data
);

   // Keystream stand-in for the cipher core; only its key use and timing matter here
   logic [DEC_CNT_W-1:0] ctr;
   logic [DEC_CNT_W-1:0] next_ctr;
   logic next_out_valid;
   logic [WORD_W-1:0] next_out_data;
   logic [WORD_W-1:0] stream;

   assign stream = key[{ctr[2:0], 5'h00} +: WORD_W] ^ {24'h00_0000, ctr};

   always_comb begin
      next_ctr = ctr;
      next_out_valid = in_valid;
      next_out_data = out_data;
      if (start) begin
         next_ctr = '0;
      end else if (in_valid) begin
         next_ctr = ctr + 8'h01;
         next_out_data = in_encrypted ? (in_data ^ stream) : in_data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctr <= '0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         ctr <= next_ctr;
         out_valid <= next_out_valid;
         out_data <= next_out_data;
      end
   end

endmodule

// File: hw/cks_security_ctrl.sv
// Functional notes
// - One 256-bit battery-backed volatile key, used to decrypt bitstreams.
// - Encrypted words are decrypted before reaching the configuration output.
// - No port anywhere returns the stored key.
// - No readback of loaded configuration; readback instruction always refused.
// - Key is scrambled before it is written into storage.
// - Key loads through JTAG key program or the core-issued key program (core_key); host programs via JTAG.
// - Core-issued key clear and key program are accepted at any time.
// - Reconfiguration starts after request returns high and status is released.
// - Pulse at each error-check cycle end with a pass or fail result.
// - With a key, both encrypted and plain bitstreams are accepted.
// - Without a key, only plain bitstreams load; encrypted ones fail.
// - JTAG key programming is accepted only in provisioning mode.
// - Provisioning unlocks the full JTAG set; otherwise instructions are restricted. Here readback stays refused even when provisioned.
// - Provisioning clears configuration data and the stored key.
// - Encrypted loads only via four listed schemes, never with decompression.
// - Logic, configuration, user memory and key can all be cleared.
module cks_security_ctrl
   import cks_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic bat_nrst,
   input wire logic config_request_n,
   output logic config_status_n_out,
   output logic config_status_n_oe,
   input wire logic jtag_instr_valid,
   input wire logic [INSTR_W-1:0] jtag_instr,
   input wire logic [KEY_W-1:0] jtag_key,
   input wire logic core_instr_valid,
   input wire logic [INSTR_W-1:0] core_instr,
   input wire logic [KEY_W-1:0] core_key,
   input wire logic bs_valid,
   output logic bs_ready,
   input wire logic [WORD_W-1:0] bs_data,
   input wire logic bs_last,
   input wire logic bs_encrypted,
   input wire logic [LOAD_W-1:0] bs_load_mode,
   input wire logic bs_decompress,
   output logic cfg_valid,
   output logic [WORD_W-1:0] cfg_data,
   output logic cfg_done,
   output logic logic_clear,
   output logic jtag_full_access,
   output logic instr_accepted,
   output logic instr_refused,
   output logic key_loaded,
   output logic [1:0] sec_mode,
   input wire logic ec_cell_flip,
   output logic ec_cycle_complete,
   output logic ec_fail
);

   typedef enum logic [2:0] {
      CFG_RESET,
      CFG_HOLD,
      CFG_LOAD,
      CFG_USER,
      CFG_FAIL
   } cks_cfg_e;

   logic req_meta;
   logic req_sync;

   cks_cfg_e state;
   cks_cfg_e next_state;
   logic [HOLD_CNT_W-1:0] hold_cnt;
   logic [HOLD_CNT_W-1:0] next_hold_cnt;
   logic cfg_started;
   logic next_cfg_started;
   logic next_jtag_full_access;
   logic next_bs_ready;
   logic next_cfg_done;
   logic next_status_oe;
   logic next_logic_clear;
   logic next_instr_accepted;
   logic next_instr_refused;
   logic [1:0] next_sec_mode;
   logic [EC_CNT_W-1:0] ec_cnt;
   logic [EC_CNT_W-1:0] next_ec_cnt;
   logic ec_err;
   logic next_ec_err;
   logic next_ec_cycle_complete;
   logic next_ec_fail;

   logic key_wr;
   logic key_clr;
   logic key_from_core;
   logic clear_all;
   logic dec_start;
   logic dec_in_valid;
   logic enc_scheme_ok;
   logic [KEY_W-1:0] key_in;
   logic [KEY_W-1:0] key_work;

   // Pin is asynchronous to clk
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         req_meta <= SYNC_RESET;
         req_sync <= SYNC_RESET;
      end else begin
         req_meta <= config_request_n;
         req_sync <= req_meta;
      end
   end

   assign key_in = key_from_core ? core_key : jtag_key;

   // Of the key storage only the valid flag reaches a port (key_loaded); the key itself goes only to the decryptor
   cks_key_store u_key_store (
      .clk(clk),
      .bat_nrst(bat_nrst),
      .wr(key_wr),
      .clr(key_clr),
      .key_in(key_in),
      .key_valid(key_loaded),
      .key_work(key_work)
   );

   cks_stream_decrypt u_decrypt (
      .clk(clk),
      .nrst(nrst),
      .start(dec_start),
      .in_valid(dec_in_valid),
      .in_data(bs_data),
      .in_encrypted(bs_encrypted),
      .key(key_work),
      .out_valid(cfg_valid),
      .out_data(cfg_data)
   );

   always_comb begin
      enc_scheme_ok = 1'b0;
      case (bs_load_mode)
         LOAD_PASSIVE_SERIAL: enc_scheme_ok = 1'b1;
         LOAD_FAST_PASSIVE_PARALLEL: enc_scheme_ok = 1'b1;
         LOAD_ACTIVE_SERIAL_FAST: enc_scheme_ok = 1'b1;
         LOAD_ACTIVE_SERIAL_UPDATE_FAST: enc_scheme_ok = 1'b1;
         default: enc_scheme_ok = 1'b0;
      endcase
   end

   always_comb begin
      next_state = state;
      next_hold_cnt = hold_cnt;
      next_cfg_started = cfg_started;
      next_jtag_full_access = jtag_full_access;
      next_cfg_done = cfg_done;
      next_status_oe = config_status_n_oe;
      next_logic_clear = 1'b0;
      next_instr_accepted = 1'b0;
      next_instr_refused = 1'b0;
      next_ec_cnt = ec_cnt;
      next_ec_err = ec_err;
      next_ec_cycle_complete = 1'b0;
      next_ec_fail = ec_fail;
      key_wr = 1'b0;
      key_clr = 1'b0;
      key_from_core = 1'b0;
      clear_all = 1'b0;
      dec_start = 1'b0;
      dec_in_valid = 1'b0;

      // Core requests win; a JTAG instruction in the same cycle is refused
      if (core_instr_valid) begin
         next_instr_accepted = 1'b1;
         case (core_instr)
            INSTR_KEY_CLEAR: key_clr = 1'b1;
            INSTR_KEY_PROGRAM: begin
               key_wr = 1'b1;
               key_from_core = 1'b1;
            end
            INSTR_CLEAR_ALL: begin
               key_clr = 1'b1;
               clear_all = 1'b1;
            end
            default: begin
               next_instr_accepted = 1'b0;
               next_instr_refused = 1'b1;
            end
         endcase
         if (jtag_instr_valid) begin
            next_instr_refused = 1'b1;
         end
      end else if (jtag_instr_valid) begin
         next_instr_accepted = 1'b1;
         case (jtag_instr)
            INSTR_BYPASS, INSTR_IDCODE: next_instr_accepted = 1'b1;
            INSTR_READBACK: begin
               next_instr_accepted = 1'b0;
               next_instr_refused = 1'b1;
            end
            INSTR_PROVISION: begin
               // Only before any configuration word has been taken
               if (!cfg_started) begin
                  next_jtag_full_access = 1'b1;
                  key_clr = 1'b1;
                  clear_all = 1'b1;
               end else begin
                  next_instr_accepted = 1'b0;
                  next_instr_refused = 1'b1;
               end
            end
            INSTR_KEY_PROGRAM: begin
               if (jtag_full_access) begin
                  key_wr = 1'b1;
               end else begin
                  next_instr_accepted = 1'b0;
                  next_instr_refused = 1'b1;
               end
            end
            default: begin
               if (jtag_full_access) begin
                  key_clr = (jtag_instr == INSTR_KEY_CLEAR);
               end else begin
                  next_instr_accepted = 1'b0;
                  next_instr_refused = 1'b1;
               end
            end
         endcase
      end

      case (state)
         CFG_RESET: begin
            next_status_oe = 1'b1;
            next_cfg_done = 1'b0;
            if (req_sync) begin
               next_state = CFG_HOLD;
               next_hold_cnt = '0;
            end
         end
         CFG_HOLD: begin
            next_hold_cnt = hold_cnt + 8'h01;
            if (hold_cnt == HOLD_LAST) begin
               next_state = CFG_LOAD;
               next_status_oe = 1'b0;
               dec_start = 1'b1;
            end
         end
         CFG_LOAD: begin
            if (bs_valid) begin
               next_cfg_started = 1'b1;
               if (bs_encrypted && (!key_loaded || !enc_scheme_ok || bs_decompress)) begin
                  next_state = CFG_FAIL;
                  next_status_oe = 1'b1;
               end else begin
                  dec_in_valid = 1'b1;
                  if (bs_last) begin
                     next_state = CFG_USER;
                     next_cfg_done = 1'b1;
                     next_ec_cnt = '0;
                     next_ec_err = 1'b0;
                  end
               end
            end
         end
         CFG_USER: begin
            next_ec_cnt = ec_cnt + 8'h01;
            next_ec_err = ec_err | ec_cell_flip;
            if (ec_cnt == EC_LAST) begin
               // A flip in the last cycle still counts toward this result
               next_ec_cycle_complete = 1'b1;
               next_ec_fail = ec_err | ec_cell_flip;
               next_ec_err = 1'b0;
            end
         end
         CFG_FAIL: next_status_oe = 1'b1;
         default: next_state = CFG_RESET;
      endcase

      // Request low or a clear throws away the whole configuration
      if (!req_sync || clear_all) begin
         next_state = CFG_RESET;
         next_status_oe = 1'b1;
         next_cfg_done = 1'b0;
         next_ec_cnt = '0;
         next_ec_err = 1'b0;
         dec_in_valid = 1'b0;
         next_logic_clear = clear_all;
      end

      next_bs_ready = (next_state == CFG_LOAD);

      // Reflects the key one cycle late, as the store registers it
      if (next_jtag_full_access) begin
         next_sec_mode = 2'(CKS_MODE_PROVISION);
      end else if (key_loaded) begin
         next_sec_mode = 2'(CKS_MODE_KEYED);
      end else begin
         next_sec_mode = 2'(CKS_MODE_KEYLESS);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= CFG_RESET;
         hold_cnt <= '0;
         cfg_started <= 1'b0;
         jtag_full_access <= 1'b0;
         bs_ready <= 1'b0;
         cfg_done <= 1'b0;
         config_status_n_oe <= 1'b1;
         logic_clear <= 1'b0;
         instr_accepted <= 1'b0;
         instr_refused <= 1'b0;
         sec_mode <= 2'(CKS_MODE_KEYLESS);
         ec_cnt <= '0;
         ec_err <= 1'b0;
         ec_cycle_complete <= 1'b0;
         ec_fail <= 1'b0;
      end else begin
         state <= next_state;
         hold_cnt <= next_hold_cnt;
         cfg_started <= next_cfg_started;
         jtag_full_access <= next_jtag_full_access;
         bs_ready <= next_bs_ready;
         cfg_done <= next_cfg_done;
         config_status_n_oe <= next_status_oe;
         logic_clear <= next_logic_clear;
         instr_accepted <= next_instr_accepted;
         instr_refused <= next_instr_refused;
         sec_mode <= next_sec_mode;
         ec_cnt <= next_ec_cnt;
         ec_err <= next_ec_err;
         ec_cycle_complete <= next_ec_cycle_complete;
         ec_fail <= next_ec_fail;
      end
   end

   // Open drain: only ever pulls low
   assign config_status_n_out = 1'b0;

endmodule

// File: tb/cks_security_ctrl_properties.sv
module cks_security_ctrl_properties
   import cks_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic config_request_n,
   input wire logic config_status_n_oe,
   input wire logic jtag_instr_valid,
   input wire logic [INSTR_W-1:0] jtag_instr,
   input wire logic core_instr_valid,
   input wire logic [INSTR_W-1:0] core_instr,
   input wire logic bs_valid,
   input wire logic bs_ready,
   input wire logic bs_encrypted,
   input wire logic [LOAD_W-1:0] bs_load_mode,
   input wire logic bs_decompress,
   input wire logic cfg_valid,
   input wire logic cfg_done,
   input wire logic logic_clear,
   input wire logic jtag_full_access,
   input wire logic instr_accepted,
   input wire logic instr_refused,
   input wire logic key_loaded,
   input wire logic [1:0] sec_mode,
   input wire logic ec_cycle_complete,
   input wire logic ec_fail
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] ec_gap;
   logic [8:0] next_gap;
   logic ec_seen;
   logic next_seen;

   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // Gap counts every cycle; ec_seen drops with cfg_done, so a reconfiguration never skews a checked gap
   always_comb begin
      next_gap = ec_gap + 9'h1;
      next_seen = ec_seen && cfg_done;
      if (ec_cycle_complete) begin
         next_gap = 9'h0;
         next_seen = cfg_done;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ec_gap <= 9'h0;
         ec_seen <= 1'b0;
      end else begin
         ec_gap <= next_gap;
         ec_seen <= next_seen;
      end
   end

   a_ready_status: assert property (bs_ready |-> !config_status_n_oe)
      else $error("load open while status held low");
   a_ready_request: assert property (!config_request_n [*5] |-> !bs_ready)
      else $error("load open while request low");
   a_cfg_follows: assert property (cfg_valid |-> $past(bs_valid && bs_ready))
      else $error("config word without a taken word");
   a_enc_nokey: assert property (bs_valid && bs_ready && bs_encrypted && !key_loaded
      |=> !bs_ready && !cfg_valid && config_status_n_oe)
      else $error("encrypted word loaded without key");
   a_bad_scheme: assert property (bs_valid && bs_ready && bs_encrypted
      && (bs_load_mode > LOAD_ACTIVE_SERIAL_UPDATE_FAST || bs_decompress)
      |=> !bs_ready && !cfg_valid)
      else $error("encrypted word taken on a barred scheme");
   a_no_readback: assert property (jtag_instr_valid && jtag_instr == INSTR_READBACK
      && !core_instr_valid |=> instr_refused && !instr_accepted)
      else $error("readback not refused");
   a_prov_clears: assert property (jtag_instr_valid && jtag_instr == INSTR_PROVISION
      && !core_instr_valid
      |=> instr_refused || (jtag_full_access && !key_loaded && logic_clear))
      else $error("provisioning did not clear and unlock");
   a_jtag_locked: assert property (jtag_instr_valid && !jtag_full_access
      && jtag_instr == INSTR_KEY_PROGRAM && !core_instr_valid
      |=> instr_refused && !instr_accepted)
      else $error("key program accepted outside provisioning");
   a_core_clear: assert property (core_instr_valid && core_instr == INSTR_KEY_CLEAR
      |=> !key_loaded ##1 sec_mode != 2'(CKS_MODE_KEYED))
      else $error("key survived a core clear");
   a_ec_period: assert property (ec_cycle_complete && ec_seen |-> ec_gap == 9'hFF)
      else $error("check cycle length wrong");

   c_provision: cover property (jtag_full_access && logic_clear);
   c_config_done: cover property ($rose(cfg_done));
   c_ec_fail: cover property (ec_cycle_complete && ec_fail);
endmodule

bind cks_security_ctrl cks_security_ctrl_properties u_props (.clk, .nrst, .config_request_n,
   .config_status_n_oe, .jtag_instr_valid, .jtag_instr, .core_instr_valid, .core_instr,
   .bs_valid, .bs_ready, .bs_encrypted, .bs_load_mode, .bs_decompress, .cfg_valid,
   .cfg_done, .logic_clear, .jtag_full_access, .instr_accepted, .instr_refused,
   .key_loaded, .sec_mode, .ec_cycle_complete, .ec_fail);

// File: tb/cks_cfg_mem.sv
module cks_cfg_mem
   import cks_pkg::*;
(
   input wire logic clk,
   input wire logic go,
   input wire logic enc,
   input wire logic [LOAD_W-1:0] mode,
   input wire logic dcmp,
   input wire logic bs_ready,
   output logic bs_valid,
   output logic [WORD_W-1:0] bs_data,
   output logic bs_last,
   output logic bs_encrypted,
   output logic [LOAD_W-1:0] bs_load_mode,
   output logic bs_decompress
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   int seed = 32'hf6d6;

   assign bs_encrypted = enc;
   assign bs_load_mode = mode;
   assign bs_decompress = dcmp;

   initial begin
      bs_valid = 1'b0;
      bs_data = '0;
      bs_last = 1'b0;
   end

   // Four words per image; random gaps act as a slow memory
   always @(posedge clk) begin
      if (!go) begin
         bs_valid <= 1'b0;
         cnt <= 0;
      end else if (bs_valid && bs_ready) begin
         // Released line shows the inverse so stale data never looks held
         bs_valid <= 1'b0;
         bs_data <= ~bs_data;
         cnt <= cnt + 1;
      end else if (!bs_valid && cnt < 4 && ($random(seed) & 1)) begin
         bs_valid <= 1'b1;
         bs_data <= $random(seed);
         bs_last <= cnt == 3;
      end
   end
endmodule

// File: tb/cks_security_ctrl_tb.sv
`define CHK(a, b) begin \
   cmp_count++; \
   if ((a) !== (b)) begin \
      miscompares++; \
      $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); \
   end \
end

module cks_security_ctrl_tb
   import cks_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, nrst, bat_nrst, config_request_n, config_status_n_out, config_status_n_oe;
   logic jtag_instr_valid, core_instr_valid, bs_valid, bs_ready, bs_last, bs_encrypted;
   logic bs_decompress, cfg_valid, cfg_done, logic_clear, jtag_full_access, key_loaded;
   logic instr_accepted, instr_refused, ec_cell_flip, ec_cycle_complete, ec_fail;
   logic go, enc, dcmp, exp_pass;
   logic [INSTR_W-1:0] jtag_instr, core_instr;
   logic [KEY_W-1:0] jtag_key, core_key;
   logic [WORD_W-1:0] bs_data, cfg_data;
   logic [LOAD_W-1:0] bs_load_mode, mode;
   logic [1:0] sec_mode;
   logic [WORD_W:0] w;
   logic [WORD_W:0] q[$];
   int miscompares, cmp_count, seed, i;
   // Status pin has a pull-up
   wire status_n = config_status_n_oe ? config_status_n_out : 1'b1;

   cks_security_ctrl dut (.clk, .nrst, .bat_nrst, .config_request_n, .config_status_n_out,
      .config_status_n_oe, .jtag_instr_valid, .jtag_instr, .jtag_key, .core_instr_valid,
      .core_instr, .core_key, .bs_valid, .bs_ready, .bs_data, .bs_last, .bs_encrypted,
      .bs_load_mode, .bs_decompress, .cfg_valid, .cfg_data, .cfg_done, .logic_clear,
      .jtag_full_access, .instr_accepted, .instr_refused, .key_loaded, .sec_mode,
      .ec_cell_flip, .ec_cycle_complete, .ec_fail);
   cks_cfg_mem mem (.clk, .go, .enc, .mode, .dcmp, .bs_ready, .bs_valid, .bs_data,
      .bs_last, .bs_encrypted, .bs_load_mode, .bs_decompress);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Model: pop per result before pushing the word taken at this edge
   always @(posedge clk) begin
      if (cfg_valid && nrst) begin
         `CHK(q.size() > 0, 1'b1)
         w = q.size() > 0 ? q.pop_front() : '0;
         if (w[WORD_W]) begin
            `CHK(cfg_data !== w[WORD_W-1:0], 1'b1)
         end else begin
            `CHK(cfg_data, w[WORD_W-1:0])
         end
      end
      if (bs_valid && bs_ready && exp_pass) q.push_back({bs_encrypted, bs_data});
   end

   task automatic tick;
      @(posedge clk);
      #1;
   endtask

   task automatic instr(input logic j, input logic [INSTR_W-1:0] c, input logic ok);
      @(posedge clk);
      if (j) begin
         jtag_instr_valid <= 1'b1;
         jtag_instr <= c;
         jtag_key <= {8{$random(seed)}};
      end else begin
         core_instr_valid <= 1'b1;
         core_instr <= c;
         core_key <= {8{$random(seed)}};
      end
      @(posedge clk);
      jtag_instr_valid <= 1'b0;
      core_instr_valid <= 1'b0;
      #1;
      `CHK({instr_accepted, instr_refused}, {ok, !ok})
      $display("test instr %0h src %0b done", c, j);
   endtask

   task automatic cfg_run(input logic e, input logic [LOAD_W-1:0] m, input logic d,
      input logic ok);
      @(posedge clk);
      config_request_n <= 1'b0;
      enc <= e;
      mode <= m;
      dcmp <= d;
      exp_pass <= ok;
      // 110 cycles keeps the request low past 500 ns
      repeat (110) @(posedge clk);
      config_request_n <= 1'b1;
      i = 0;
      while (i++ < 400 && bs_ready !== 1'b1) tick;
      `CHK(status_n, 1'b1)
      @(posedge clk);
      go <= 1'b1;
      i = 0;
      while (i++ < 80 && cfg_done !== 1'b1) tick;
      `CHK({cfg_done, config_status_n_oe}, {ok, !ok})
      @(posedge clk);
      go <= 1'b0;
      tick;
      `CHK(q.size(), 0)
      $display("test cfg enc %0b mode %0d dcmp %0b done", e, m, d);
   endtask

   task automatic ec_wait(input logic flip, input logic exp);
      @(posedge clk);
      ec_cell_flip <= flip;
      @(posedge clk);
      ec_cell_flip <= 1'b0;
      i = 0;
      while (i++ < 300 && ec_cycle_complete !== 1'b1) tick;
      `CHK({ec_cycle_complete, ec_fail}, {1'b1, exp})
      $display("test error check flip %0b done", flip);
   endtask

   task end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      end_of_test;
   end

   initial begin
      seed = 32'hf6d6;
      {nrst, bat_nrst, config_request_n, jtag_instr_valid, core_instr_valid} = '0;
      {go, enc, dcmp, exp_pass, ec_cell_flip} = '0;
      {jtag_instr, core_instr, jtag_key, core_key, mode} = '0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      bat_nrst <= 1'b1;
      // Supply settle wait before keying, scaled down: milliseconds do not fit the run
      repeat (20) @(posedge clk);
      instr(1'b1, INSTR_PROVISION, 1'b1);
      `CHK({jtag_full_access, logic_clear, key_loaded, sec_mode}, 5'b11010)
      instr(1'b1, INSTR_READBACK, 1'b0);
      instr(1'b1, INSTR_KEY_PROGRAM, 1'b1);
      `CHK(key_loaded, 1'b1)
      instr(1'b1, INSTR_KEY_CLEAR, 1'b1);
      `CHK(key_loaded, 1'b0)
      instr(1'b1, INSTR_KEY_PROGRAM, 1'b1);
      `CHK(key_loaded, 1'b1)
      cfg_run(1'b1, LOAD_PASSIVE_SERIAL, 1'b0, 1'b1);
      ec_wait(1'b0, 1'b0);
      ec_wait(1'b1, 1'b1);
      ec_wait(1'b0, 1'b0);
      instr(1'b0, INSTR_KEY_CLEAR, 1'b1);
      `CHK(key_loaded, 1'b0)
      cfg_run(1'b1, LOAD_PASSIVE_SERIAL, 1'b0, 1'b0);
      cfg_run(1'b0, LOAD_PARALLEL_FLASH, 1'b0, 1'b1);
      instr(1'b0, INSTR_KEY_PROGRAM, 1'b1);
      for (int m = 0; m < 6; m++) cfg_run(1'b1, LOAD_W'(m), 1'b0, m < 4);
      cfg_run(1'b1, LOAD_FAST_PASSIVE_PARALLEL, 1'b1, 1'b0);
      cfg_run(1'b0, LOAD_ACTIVE_SERIAL, 1'b0, 1'b1);
      instr(1'b0, INSTR_READBACK, 1'b0);
      instr(1'b0, INSTR_CLEAR_ALL, 1'b1);
      `CHK({logic_clear, key_loaded}, 2'b10)
      instr(1'b0, INSTR_KEY_PROGRAM, 1'b1);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      tick;
      `CHK({key_loaded, jtag_full_access}, 2'b10)
      instr(1'b1, INSTR_KEY_PROGRAM, 1'b0);
      instr(1'b1, INSTR_IDCODE, 1'b1);
      instr(1'b1, INSTR_BYPASS, 1'b1);
      tick;
      `CHK(sec_mode, 2'(CKS_MODE_KEYED))
      cfg_run(1'b0, LOAD_PASSIVE_SERIAL, 1'b0, 1'b1);
      instr(1'b1, INSTR_PROVISION, 1'b0);
      end_of_test;
   end
endmodule
